/* File: hdl/ext_bus_strobes.sv */
/*
 * external bus strobes and reset output: latch strobe, program store strobe, reset_out_n.
 * assumes mclk is the crystal input, the core supplies fetch and reset-cause levels on mclk,
 * and the pins reset_in and addr_data_share_select come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_strobes
  import strobe_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reset_in,
  input wire logic addr_data_share_select,
  input wire logic latch_strobe_off,
  input wire logic rom_fetch,
  input wire logic [7:0] addr_low,
  input wire logic [7:0] data_out,
  input wire logic data_drive,
  input wire logic [7:0] port0_in,
  input wire logic warmup_active,
  input wire logic osc_fail,
  input wire logic osc_fail_reset_enable,
  input wire logic supply_low,
  input wire logic watchdog_reset,
  output logic addr_latch_strobe,
  output logic program_store_strobe,
  output logic reset_out_n,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] data_in,
  output logic mux_mode
);
  strobe_if sif (); // phase link to the counter
  logic rst_meta, rst_sync; // reset pin synchroniser
  logic mux_meta, mux_sync; // strap pin synchroniser
  logic strap_taken; // strap captured once after release
  logic [1:0] strap_wait; // edges counted while the strap synchroniser fills
  logic wd_prev; // watchdog edge detect
  logic [1:0] wd_count; // remaining watchdog reset-out cycles
  logic strobe_pos; // posedge part of strobe
  logic strobe_neg; // negedge half-cycle extension
  logic strobe_raw; // combined 1.5-cycle pulse
  logic strobe_forced; // forced-high condition
  logic in_reset; // any reset cause active
  logic strobe_stage; // forced-or-raw strobe, not registered
  logic [7:0] next_port0; // port 0 output select

  strobe_phase u_phase (
    .mclk(mclk),
    .rstn(rstn),
    .sif(sif)
  );

  // two-flop synchronisers for pins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      mux_meta <= 1'b0;
      mux_sync <= 1'b0;
    end else begin
      rst_meta <= reset_in;
      rst_sync <= rst_meta;
      mux_meta <= addr_data_share_select;
      mux_sync <= mux_meta;
    end
  end

  // strap is read once after reset release and then held
  // the synchroniser still holds its reset value for two edges, so wait for it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strap_taken <= 1'b0;
      strap_wait <= 2'h0;
      mux_mode <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_wait == STRAP_SETTLE) begin
        // synchroniser now shows the pin level
        strap_taken <= 1'b1;
        mux_mode <= mux_sync;
      end else begin
        // still filling
        strap_wait <= 2'(strap_wait + 2'h1);
      end
    end
  end

  // watchdog reset stretcher: exactly two cycles per rising event
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wd_prev <= 1'b0;
      wd_count <= 2'h0;
    end else begin
      wd_prev <= watchdog_reset;
      if (watchdog_reset && !wd_prev) begin
        wd_count <= WDOG_RESET_CYCLES;
      end else if (wd_count != 2'h0) begin
        wd_count <= 2'(wd_count - 2'h1);
      end
    end
  end

  // any cause of reset drives the reset output low
  assign in_reset = rst_sync || warmup_active || (osc_fail && osc_fail_reset_enable)
    || supply_low || (wd_count != 2'h0);
  assign sif.run = !in_reset;

  // strobe high for phase 0 then half of phase 2 via the falling-edge stage
  // only phase 0 counts a whole cycle; the falling-edge stage adds the last half
  assign strobe_pos = (sif.phase < 3'(STROBE_HIGH_HALVES - 3'h1));
  always_ff @(negedge mclk or negedge rstn) begin
    if (!rstn) begin
      strobe_neg <= 1'b1;
    end else begin
      strobe_neg <= strobe_pos;
    end
  end
  assign strobe_raw = strobe_pos || strobe_neg;
  // until the strap is known the latch strobe is forced high as in reset
  assign strobe_forced = in_reset || !strap_taken || (mux_mode && latch_strobe_off);

  // in both modes the strobe toggles unless forced high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reset_out_n <= 1'b0;
      program_store_strobe <= 1'b1;
    end else begin
      reset_out_n <= !in_reset;
      program_store_strobe <= !(rom_fetch && !in_reset);
    end
  end
  assign strobe_stage = strobe_forced ? 1'b1 : strobe_raw;
  assign addr_latch_strobe = strobe_stage;

  // port 0 carries the low address while strobe high in multiplexed mode
  assign next_port0 = (!mux_mode && strobe_stage) ? addr_low : data_out;
  assign port0_out = next_port0;
  assign port0_oe = (!mux_mode && strobe_stage) || data_drive;

  // read data from port 0 is registered before it reaches the core
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_in <= 8'h00;
    end else begin
      data_in <= port0_in;
    end
  end

  // watchdog event yields exactly two low reset-out cycles
  sequence wd_event;
    watchdog_reset && !wd_prev;
  endsequence
  AST_WDOG_TWO: assert property (@(posedge mclk) disable iff (!rstn)
    wd_event |=> (wd_count != 2'h0) ##1 (wd_count != 2'h0))
    else $error("watchdog reset not stretched two cycles");
  AST_STROBE_FORCED: assert property (@(posedge mclk) disable iff (!rstn)
    strobe_forced |-> addr_latch_strobe)
    else $error("latch strobe not high while forced");
  AST_RESET_OUT: assert property (@(posedge mclk) disable iff (!rstn)
    supply_low |=> !reset_out_n)
    else $error("reset output not low for low supply");
  AST_PROG_IDLE: assert property (@(posedge mclk) disable iff (!rstn)
    !rom_fetch |=> program_store_strobe)
    else $error("program store strobe low without fetch");
  AST_PERIOD: assert property (@(posedge mclk) disable iff (!rstn)
    (sif.run && $past(sif.run) && sif.phase == PHASE_RESET) |-> ##4 (sif.phase == PHASE_RESET)
      || !sif.run)
    else $error("strobe period not four cycles");
  AST_PIN_RESET: assert property (@(posedge mclk) disable iff (!rstn)
    reset_in |-> ##2 in_reset)
    else $error("reset pin not honoured");
  AST_PORT0_ADDR: assert property (@(posedge mclk) disable iff (!rstn)
    (!mux_mode && addr_latch_strobe) |-> (port0_out == addr_low && port0_oe))
    else $error("port 0 not carrying low address");
  AST_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn)
    (!strobe_forced && sif.phase == 3'h6) |-> !addr_latch_strobe)
    else $error("strobe not toggling");
  // watchdog stretch must end after its two cycles when no new event comes
  sequence wd_quiet_after;
    wd_event ##1 (!wd_event) [*2];
  endsequence
  AST_WDOG_END: assert property (@(posedge mclk) disable iff (!rstn)
    wd_quiet_after |=> (wd_count == 2'h0))
    else $error("watchdog reset longer than two cycles");
  // a fetch outside reset pulls the program store strobe low
  AST_PSS_FETCH: assert property (@(posedge mclk) disable iff (!rstn)
    (rom_fetch && !in_reset) |=> !program_store_strobe)
    else $error("program store strobe not low during fetch");
  AST_OSC_FAIL: assert property (@(posedge mclk) disable iff (!rstn)
    (osc_fail && osc_fail_reset_enable) |=> !reset_out_n)
    else $error("reset output not low for oscillator failure");
  AST_WARMUP: assert property (@(posedge mclk) disable iff (!rstn)
    warmup_active |=> !reset_out_n)
    else $error("reset output not low during warm-up");
  AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    strap_taken |=> $stable(mux_mode))
    else $error("bus mode changed after strap capture");
  AST_DEMUX_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn)
    (mux_mode && !strobe_forced && sif.phase == 3'h0) |-> addr_latch_strobe)
    else $error("strobe not high at start of period in demultiplexed mode");
  AST_PORT0_DATA: assert property (@(posedge mclk) disable iff (!rstn)
    (!addr_latch_strobe && !data_drive) |-> !port0_oe)
    else $error("port 0 driven after strobe fell");
  // a rising strobe is seen high for one sampled cycle, then low for three
  sequence strobe_rise;
    !addr_latch_strobe ##1 addr_latch_strobe;
  endsequence
  AST_HIGH_WIDTH: assert property (@(posedge mclk) disable iff (!rstn || strobe_forced)
    strobe_rise |=> (!addr_latch_strobe) [*3] ##1 addr_latch_strobe)
    else $error("strobe shape not one high of four cycles");
endmodule : ext_bus_strobes
`default_nettype wire

/* File: hdl/strobe_pkg.sv */
/*
 * constants for the external bus strobe and reset output block.
 * assumes mclk stands for the crystal input clock; one mclk cycle is one crystal cycle.
 */
package strobe_pkg;
  // crystal cycles in one latch strobe period
  localparam logic [2:0] STROBE_PERIOD = 3'h4;
  // half-cycles the strobe stays high (1.5 crystal cycles)
  localparam logic [2:0] STROBE_HIGH_HALVES = 3'h3;
  // half-cycles in one period
  localparam logic [3:0] STROBE_PERIOD_HALVES = 4'h8;
  // edges waited after release before the strap pin has passed its synchroniser
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // cycles of reset output after a watchdog reset
  localparam logic [1:0] WDOG_RESET_CYCLES = 2'h2;
  // reset value of the phase counter
  localparam logic [2:0] PHASE_RESET = 3'h0;
endpackage : strobe_pkg

/* File: hdl/strobe_if.sv */
/*
 * interface carrying the half-cycle phase between the phase generator and the top.
 * assumes one clock domain, mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
  logic [2:0] phase; // half-cycle phase 0..7
  logic run; // phase counter enable
  modport gen (input run, output phase);
  modport use_side (output run, input phase);
endinterface : strobe_if
`default_nettype wire

/* File: hdl/strobe_phase.sv */
/*
 * half-cycle phase counter for the latch strobe.
 * assumes mclk is the crystal clock and rstn an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module strobe_phase
  import strobe_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  strobe_if.gen sif
);
  logic [2:0] phase; // counts half crystal cycles, wraps at eight
  logic [2:0] next_phase; // counter advance

  // a period of four crystal cycles is eight halves, so a 3-bit counter wraps on its own
  assign next_phase = sif.run ? 3'(phase + 3'h2) : PHASE_RESET;

  // full cycle steps of two halves; the half step is made by the falling-edge stage in top
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  assign sif.phase = phase;
endmodule : strobe_phase
`default_nettype wire

/* File: tb/latch_rom_model.sv */
/* external transparent address latch and program rom model.
   assumes the bus is driven by the block under test. */
`timescale 1ns/1ps
`default_nettype none
module latch_rom_model (
  input wire logic latch_en,
  input wire logic rom_ce_n,
  input wire logic [7:0] bus,
  output logic [7:0] addr_q,
  output logic [7:0] rom_data
);
  // the bus reaches the latch a little late, as on a board, so the
  // address is still there when the strobe falls
  wire logic [7:0] bus_late;
  assign #1 bus_late = bus;
  // latch follows the bus while the strobe is high
  always_latch begin
    if (latch_en) addr_q <= bus_late;
  end
  // rom answers only when selected, else shows the inverse of the latched address
  always_comb begin
    rom_data = rom_ce_n ? ~addr_q : addr_q;
  end
endmodule : latch_rom_model
`default_nettype wire

/* File: tb/ext_bus_strobes_reset_out_bench.sv */
/* self-checking bench for the bus strobes and reset output.
   assumes one 100 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ext_bus_strobes_reset_out_bench;
  import strobe_pkg::*;
  logic mclk, rstn, rin, sel, off, fetch, drv, wu, of, ofe, sup, wd;
  logic [7:0] addr_low, data_out, p0_in, p0_out, din, addr_q;
  logic ale, pss, rout_n, oe, mm;
  int num_errors = 0, checked = 0, n;
  realtime t0, t1, t2;
  logic [5:0] causes [6] = '{6'h20, 6'h10, 6'h0c, 6'h08, 6'h01, 6'h04};
  logic exp_out [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  ext_bus_strobes ext_bus_strobes_i (.mclk(mclk), .rstn(rstn), .reset_in(rin),
    .addr_data_share_select(sel), .latch_strobe_off(off), .rom_fetch(fetch),
    .addr_low(addr_low), .data_out(data_out), .data_drive(drv), .port0_in(p0_in),
    .warmup_active(wu), .osc_fail(of), .osc_fail_reset_enable(ofe), .supply_low(sup),
    .watchdog_reset(wd), .addr_latch_strobe(ale), .program_store_strobe(pss),
    .reset_out_n(rout_n), .port0_out(p0_out), .port0_oe(oe), .data_in(din), .mux_mode(mm));
  latch_rom_model latch_rom_model_i (.latch_en(ale), .rom_ce_n(pss), .bus(p0_out),
    .addr_q(addr_q), .rom_data(p0_in));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // reset with a given strap and check the reset levels of the outputs
  task automatic do_reset(input logic strap);
    @(negedge mclk) rstn = 0;
    sel = strap;
    repeat (5) @(negedge mclk);
    `CHK(ale, 1'b1)
    `CHK(pss, 1'b1)
    `CHK(rout_n, 1'b0)
    rstn = 1;
    repeat (4) @(negedge mclk);
    `CHK(mm, strap)
    $display("test reset done");
  endtask : do_reset
  // measure high time and period of the latch strobe
  task automatic strobe_timing();
    @(posedge ale) t0 = $realtime;
    @(negedge ale) t1 = $realtime;
    @(posedge ale) t2 = $realtime;
    `CHK(int'(t1 - t0), 15)
    `CHK(int'(t2 - t0), 40)
    $display("test strobe timing done");
  endtask : strobe_timing
  // each reset cause, one at a time
  task automatic reset_causes();
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk) {rin, wu, of, ofe, wd, sup} = causes[i];
      repeat (4) @(negedge mclk);
      `CHK(rout_n, exp_out[i])
      {rin, wu, of, ofe, wd, sup} = 6'h00;
      repeat (4) @(negedge mclk);
      `CHK(rout_n, 1'b1)
    end
    @(negedge mclk) wd = 1;
    @(negedge mclk) wd = 0;
    n = 0;
    repeat (8) @(negedge mclk) n += int'(!rout_n);
    `CHK(n, 2)
    $display("test reset causes done");
  endtask : reset_causes
  // rom fetch and address latching
  task automatic fetch_and_latch();
    @(negedge mclk) addr_low = 8'ha5;
    fetch = 1;
    @(negedge mclk);
    `CHK(pss, 1'b0)
    fetch = 0;
    @(negedge mclk);
    `CHK(pss, 1'b1)
    @(posedge ale) #1;
    `CHK(p0_out, 8'ha5)
    `CHK(oe, 1'b1)
    @(negedge ale) #1;
    `CHK(addr_q, 8'ha5)
    @(negedge mclk) fetch = 1;
    @(negedge mclk) fetch = 0;
    @(negedge mclk);
    `CHK(din, 8'ha5)
    $display("test fetch and latch done");
  endtask : fetch_and_latch
  // strobe held high while switched off in demultiplexed mode
  task automatic strobe_off();
    off = 1;
    do_reset(1'b1);
    n = 0;
    repeat (12) @(negedge mclk) n += int'(!ale);
    `CHK(n, 0)
    off = 0;
    strobe_timing();
    $display("test strobe off done");
  endtask : strobe_off
  initial begin
    {rstn, rin, sel, off, fetch, drv, wu, of, ofe, sup, wd} = '0;
    addr_low = 8'h00;
    data_out = 8'h3c;
    do_reset(1'b0);
    strobe_timing();
    fetch_and_latch();
    reset_causes();
    strobe_off();
    conclude();
  end
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
endmodule : ext_bus_strobes_reset_out_bench
`default_nettype wire
